// ==== scd_defs.vh ====
// Constants of the clock-enable state and command decoder.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef SCD_DEFS_VH
`define SCD_DEFS_VH

// ==========================================================
// Decoder states
`define SCD_ST_IDLE 3'h0
`define SCD_ST_ACTIVE 3'h1
`define SCD_ST_READ 3'h2
`define SCD_ST_WRITE 3'h3
`define SCD_ST_PD_PRE 3'h4
`define SCD_ST_PD_ACT 3'h5
`define SCD_ST_SELF 3'h6

// ==========================================================
// Commands decoded from cs_n, ras_n, cas_n, we_n
`define SCD_CMD_DESELECT 3'h0
`define SCD_CMD_NOP 3'h1
`define SCD_CMD_READ 3'h2
`define SCD_CMD_STORE 3'h3
`define SCD_CMD_ROW_OPEN 3'h4
`define SCD_CMD_BANK_CLOSE 3'h5
`define SCD_CMD_REFRESH 3'h6
`define SCD_CMD_MODE_LOAD 3'h7

// ==========================================================
// Action codes reported with action_valid
`define SCD_ACT_ROW_OPEN 3'h0
`define SCD_ACT_BANK_CLOSE 3'h1
`define SCD_ACT_AUTO_REFRESH 3'h2
`define SCD_ACT_MODE_LOAD 3'h3
`define SCD_ACT_READ 3'h4
`define SCD_ACT_STORE 3'h5
`define SCD_ACT_PD_ENTRY 3'h6
`define SCD_ACT_EXIT 3'h7

// ==========================================================
// Timing counts, in memory clock edges
`define SCD_XSRD_CLKS 8'h00_C8
`define SCD_XSNR_CLKS 8'h00_0A
`define SCD_CKE_HOLD_CLKS 2'h3
`define SCD_SHORT_BURST 4'h4

`endif

// ==== scd_sync.v ====
// Two-flop synchroniser for a group of independent levels.
// Assumes each bit is a level stable for several ref_clk periods.
`timescale 1ns/1ps
module scd_sync #(
  parameter WIDTH = 1
) (
  input wire ref_clk,
  input wire nrst,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  always @(posedge ref_clk) begin
    if (!nrst) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule // scd_sync

// ==== scd_buf.v ====
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock; both sides may act in the same cycle.
`timescale 1ns/1ps
module scd_buf #(
  parameter WIDTH = 8,
  parameter DEPTH = 2
) (
  input wire ref_clk,
  input wire nrst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg rd_idx_ff;
  reg wr_idx_ff;
  reg [1:0] count_ff;
  wire do_push;
  wire do_pop;

  assign in_ready = (count_ff != DEPTH[1:0]);
  assign out_valid = (count_ff != 2'h0);
  assign out_data = mem_ff[rd_idx_ff];
  assign do_push = in_valid & in_ready;
  assign do_pop = out_valid & out_ready;

  // ==========================================================
  // Storage and pointers
  always @(posedge ref_clk) begin
    if (do_push) begin
      mem_ff[wr_idx_ff] <= in_data;
    end
  end

  always @(posedge ref_clk) begin
    if (!nrst) begin
      rd_idx_ff <= 1'b0;
      wr_idx_ff <= 1'b0;
      count_ff <= 2'h0;
    end else begin
      if (do_push) begin
        wr_idx_ff <= ~wr_idx_ff;
      end
      if (do_pop) begin
        rd_idx_ff <= ~rd_idx_ff;
      end
      if (do_push && !do_pop) begin
        count_ff <= count_ff + 2'h1;
      end else if (do_pop && !do_push) begin
        count_ff <= count_ff - 2'h1;
      end
    end
  end
endmodule // scd_buf

// ==== scd_cmd_decoder.v ====
// Clock-enable state and command decoder of a DDR2 memory device.
// Assumes mem_clk and all memory pins are asynchronous to ref_clk and
// that mem_clk is at least four times slower than ref_clk.
// Overview of operation
// - Act on previous CKE, current CKE, command
// - CKE fall with NOP enters power-down
// - Self-refresh only from idle via refresh
// - Low CKE holds state, ignores commands
// - ON_DIE_TERMINATION no effect; unavailable in self-refresh
// - Unlisted combinations are illegal
// - No refresh activity during power-down
// - Mask low stores beat, high inhibits
// - Idle state command actions
// - Banks-active state command actions
// - Read burst command actions
// - Write burst command actions
// - Commands decoded from strobes at edge
// - Four-beat bursts cannot be interrupted
`timescale 1ns/1ps
`include "scd_defs.vh"
module scd_cmd_decoder #(
  parameter DATA_W = 8,
  parameter BURST_LEN = 4,
  parameter XSNR_CLKS = 8
) (
  input wire ref_clk,
  input wire nrst,
  input wire mem_clk,
  input wire cke,
  input wire cs_n,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire on_die_termination,
  input wire data_mask_input,
  input wire [DATA_W-1:0] dq,
  output wire [2:0] bank_state,
  output wire illegal_cmd,
  output wire cke_hold_err,
  output wire action_valid,
  output wire [2:0] action_code,
  output wire odt_effective,
  output wire beat_lost,
  output wire beat_valid,
  input wire beat_ready,
  output wire [DATA_W-1:0] beat_data
);
  // ==========================================================
  // Synchronisers
  wire [DATA_W+7:0] raw_pins;
  wire [DATA_W+7:0] sync_pins;
  wire s_clk;
  wire s_cke;
  wire s_cs_n;
  wire s_ras_n;
  wire s_cas_n;
  wire s_we_n;
  wire s_odt;
  wire s_dm;
  wire [DATA_W-1:0] s_dq;

  assign raw_pins = {dq, data_mask_input, on_die_termination, we_n, cas_n, ras_n, cs_n, cke, mem_clk};

  scd_sync #(
    .WIDTH(DATA_W + 8)
  ) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .async_in(raw_pins),
    .sync_out(sync_pins)
  );

  assign s_clk = sync_pins[0];
  assign s_cke = sync_pins[1];
  assign s_cs_n = sync_pins[2];
  assign s_ras_n = sync_pins[3];
  assign s_cas_n = sync_pins[4];
  assign s_we_n = sync_pins[5];
  assign s_odt = sync_pins[6];
  assign s_dm = sync_pins[7];
  assign s_dq = sync_pins[DATA_W+7:8];

  // ==========================================================
  // Command decode
  function [2:0] decode_cmd;
    input cs_b;
    input ras_b;
    input cas_b;
    input we_b;
    begin
      if (cs_b) begin
        decode_cmd = `SCD_CMD_DESELECT;
      end else begin
        decode_cmd = {~ras_b, ~(ras_b ? cas_b : cas_b), ~we_b};
        case ({ras_b, cas_b, we_b})
          3'b111: decode_cmd = `SCD_CMD_NOP;
          3'b101: decode_cmd = `SCD_CMD_READ;
          3'b100: decode_cmd = `SCD_CMD_STORE;
          3'b011: decode_cmd = `SCD_CMD_ROW_OPEN;
          3'b010: decode_cmd = `SCD_CMD_BANK_CLOSE;
          3'b001: decode_cmd = `SCD_CMD_REFRESH;
          3'b000: decode_cmd = `SCD_CMD_MODE_LOAD;
          default: decode_cmd = `SCD_CMD_NOP;
        endcase
      end
    end
  endfunction

  reg clk_d_ff;
  wire edge_hit;
  wire [2:0] cmd;
  wire quiet;

  assign edge_hit = s_clk & ~clk_d_ff;
  assign cmd = decode_cmd(s_cs_n, s_ras_n, s_cas_n, s_we_n);
  assign quiet = (cmd == `SCD_CMD_DESELECT) || (cmd == `SCD_CMD_NOP);

  // ==========================================================
  // State registers
  reg [2:0] state_ff;
  reg cke_prev_ff;
  reg [3:0] burst_cnt_ff;
  reg [7:0] xsr_cnt_ff;
  reg [1:0] hold_cnt_ff;
  reg illegal_ff;
  reg hold_err_ff;
  reg action_valid_ff;
  reg [2:0] action_code_ff;
  reg odt_eff_ff;
  reg beat_lost_ff;

  reg [2:0] nxt_state;
  reg [3:0] nxt_burst_cnt;
  reg [7:0] nxt_xsr_cnt;
  reg nxt_illegal;
  reg nxt_action_valid;
  reg [2:0] nxt_action_code;
  reg beat_push;
  wire beat_in_ready;
  wire in_nonread_win;
  wire read_blocked;

  // Self-refresh exit window tracked in edges after exit
  assign in_nonread_win = (xsr_cnt_ff > (`SCD_XSRD_CLKS - XSNR_CLKS[7:0]));
  assign read_blocked = (xsr_cnt_ff != 8'h00);

  // ==========================================================
  // Next-state decision per edge
  always @* begin
    nxt_state = state_ff;
    nxt_burst_cnt = burst_cnt_ff;
    nxt_xsr_cnt = (xsr_cnt_ff != 8'h00) ? xsr_cnt_ff - 8'h01 : 8'h00;
    nxt_illegal = 1'b0;
    nxt_action_valid = 1'b0;
    nxt_action_code = `SCD_ACT_ROW_OPEN;
    beat_push = 1'b0;
    case (state_ff)
      `SCD_ST_PD_PRE, `SCD_ST_PD_ACT: begin
        if (s_cke) begin
          // Exit only with a quiet command
          if (quiet && !cke_prev_ff) begin
            nxt_state = (state_ff == `SCD_ST_PD_PRE) ? `SCD_ST_IDLE : `SCD_ST_ACTIVE;
            nxt_action_valid = 1'b1;
            nxt_action_code = `SCD_ACT_EXIT;
          end else begin
            nxt_illegal = 1'b1;
          end
        end
        // Low CKE: commands ignored, no refresh issued
      end
      `SCD_ST_SELF: begin
        if (s_cke) begin
          if (quiet && !cke_prev_ff) begin
            nxt_state = `SCD_ST_IDLE;
            nxt_xsr_cnt = `SCD_XSRD_CLKS;
            nxt_action_valid = 1'b1;
            nxt_action_code = `SCD_ACT_EXIT;
          end else begin
            nxt_illegal = 1'b1;
          end
        end
      end
      default: begin
        if (!cke_prev_ff) begin
          nxt_illegal = 1'b1;
        end else if (!s_cke) begin
          // Falling CKE: entry decisions
          if (state_ff == `SCD_ST_IDLE && quiet) begin
            nxt_state = `SCD_ST_PD_PRE;
            nxt_action_valid = 1'b1;
            nxt_action_code = `SCD_ACT_PD_ENTRY;
          end else if (state_ff == `SCD_ST_ACTIVE && quiet) begin
            nxt_state = `SCD_ST_PD_ACT;
            nxt_action_valid = 1'b1;
            nxt_action_code = `SCD_ACT_PD_ENTRY;
          end else if (state_ff == `SCD_ST_IDLE && cmd == `SCD_CMD_REFRESH) begin
            nxt_state = `SCD_ST_SELF;
            nxt_action_valid = 1'b1;
            nxt_action_code = `SCD_ACT_PD_ENTRY;
          end else begin
            // Bursts, refresh from active, busy commands
            nxt_illegal = 1'b1;
          end
        end else if (in_nonread_win && !quiet) begin
          nxt_illegal = 1'b1;
        end else begin
          case (state_ff)
            `SCD_ST_IDLE: begin
              case (cmd)
                `SCD_CMD_ROW_OPEN: begin
                  nxt_state = `SCD_ST_ACTIVE;
                  nxt_action_valid = 1'b1;
                  nxt_action_code = `SCD_ACT_ROW_OPEN;
                end
                `SCD_CMD_BANK_CLOSE: begin
                  nxt_action_valid = 1'b1;
                  nxt_action_code = `SCD_ACT_BANK_CLOSE;
                end
                `SCD_CMD_REFRESH: begin
                  nxt_action_valid = 1'b1;
                  nxt_action_code = `SCD_ACT_AUTO_REFRESH;
                end
                `SCD_CMD_MODE_LOAD: begin
                  nxt_action_valid = 1'b1;
                  nxt_action_code = `SCD_ACT_MODE_LOAD;
                end
                `SCD_CMD_READ, `SCD_CMD_STORE: nxt_illegal = 1'b1;
                default: nxt_state = state_ff;
              endcase
            end
            `SCD_ST_ACTIVE: begin
              case (cmd)
                `SCD_CMD_READ: begin
                  if (read_blocked) begin
                    nxt_illegal = 1'b1;
                  end else begin
                    nxt_state = `SCD_ST_READ;
                    nxt_burst_cnt = BURST_LEN[3:0];
                    nxt_action_valid = 1'b1;
                    nxt_action_code = `SCD_ACT_READ;
                  end
                end
                `SCD_CMD_STORE: begin
                  nxt_state = `SCD_ST_WRITE;
                  nxt_burst_cnt = BURST_LEN[3:0];
                  nxt_action_valid = 1'b1;
                  nxt_action_code = `SCD_ACT_STORE;
                end
                `SCD_CMD_BANK_CLOSE: begin
                  nxt_state = `SCD_ST_IDLE;
                  nxt_action_valid = 1'b1;
                  nxt_action_code = `SCD_ACT_BANK_CLOSE;
                end
                `SCD_CMD_ROW_OPEN, `SCD_CMD_REFRESH, `SCD_CMD_MODE_LOAD: begin
                  nxt_illegal = 1'b1;
                end
                default: nxt_state = state_ff;
              endcase
            end
            default: begin
              // Read or write burst in progress
              if (state_ff == `SCD_ST_WRITE) begin
                beat_push = ~s_dm;
              end
              if (quiet) begin
                if (burst_cnt_ff <= 4'h1) begin
                  nxt_state = `SCD_ST_ACTIVE;
                end
                nxt_burst_cnt = burst_cnt_ff - 4'h1;
              end else if ((state_ff == `SCD_ST_READ && cmd == `SCD_CMD_READ) ||
                  (state_ff == `SCD_ST_WRITE && cmd == `SCD_CMD_STORE)) begin
                if (BURST_LEN > `SCD_SHORT_BURST) begin
                  nxt_burst_cnt = BURST_LEN[3:0];
                  nxt_action_valid = 1'b1;
                  nxt_action_code = (state_ff == `SCD_ST_READ) ? `SCD_ACT_READ :
                    `SCD_ACT_STORE;
                end else begin
                  nxt_illegal = 1'b1;
                end
              end else begin
                nxt_illegal = 1'b1;
              end
            end
          endcase
        end
      end
    endcase
  end

  // ==========================================================
  // Edge detector and termination registered every ref_clk, pulse flags cleared every ref_clk; the rest on each detected memory clock edge
  always @(posedge ref_clk) begin
    if (!nrst) begin
      clk_d_ff <= 1'b0;
      state_ff <= `SCD_ST_IDLE;
      cke_prev_ff <= 1'b1;
      burst_cnt_ff <= 4'h0;
      xsr_cnt_ff <= 8'h00;
      hold_cnt_ff <= `SCD_CKE_HOLD_CLKS - 2'h1;
      illegal_ff <= 1'b0;
      hold_err_ff <= 1'b0;
      action_valid_ff <= 1'b0;
      action_code_ff <= `SCD_ACT_ROW_OPEN;
      odt_eff_ff <= 1'b0;
      beat_lost_ff <= 1'b0;
    end else begin
      clk_d_ff <= s_clk;
      // ON_DIE_TERMINATION gated by self-refresh only, never steers state
      odt_eff_ff <= s_odt & (state_ff != `SCD_ST_SELF);
      illegal_ff <= 1'b0;
      hold_err_ff <= 1'b0;
      action_valid_ff <= 1'b0;
      beat_lost_ff <= 1'b0;
      if (edge_hit) begin
        state_ff <= nxt_state;
        burst_cnt_ff <= nxt_burst_cnt;
        xsr_cnt_ff <= nxt_xsr_cnt;
        illegal_ff <= nxt_illegal;
        action_valid_ff <= nxt_action_valid;
        action_code_ff <= nxt_action_code;
        cke_prev_ff <= s_cke;
        // Change before third registration flagged
        if (s_cke != cke_prev_ff) begin
          hold_cnt_ff <= 2'h0;
          hold_err_ff <= (hold_cnt_ff < `SCD_CKE_HOLD_CLKS - 2'h1);
        end else if (hold_cnt_ff < `SCD_CKE_HOLD_CLKS - 2'h1) begin
          hold_cnt_ff <= hold_cnt_ff + 2'h1;
        end
        // Receiver stall: beat dropped only when both entries full
        beat_lost_ff <= beat_push & ~beat_in_ready;
      end
    end
  end

  // ==========================================================
  // Stored-beat buffer
  scd_buf #(
    .WIDTH(DATA_W),
    .DEPTH(2)
  ) u_buf (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .in_valid(edge_hit & beat_push),
    .in_ready(beat_in_ready),
    .in_data(s_dq),
    .out_valid(beat_valid),
    .out_ready(beat_ready),
    .out_data(beat_data)
  );

  assign bank_state = state_ff;
  assign illegal_cmd = illegal_ff;
  assign cke_hold_err = hold_err_ff;
  assign action_valid = action_valid_ff;
  assign action_code = action_code_ff;
  assign odt_effective = odt_eff_ff;
  assign beat_lost = beat_lost_ff;
endmodule // scd_cmd_decoder

// ==== scd_ctrl_model.sv ====
// Memory controller model driving clock, clock enable, strobes, mask, data.
// Assumes one caller of issue() at a time, each call just after a ref_clk rise.
`timescale 1ns/1ps
`include "scd_defs.vh"
module scd_ctrl_model (
  input wire ref_clk,
  output logic mem_clk,
  output logic cke,
  output logic [3:0] strb,
  output logic dm,
  output logic [7:0] dq
);
  initial begin
    mem_clk = 1'b0;
    cke = 1'b1;
    strb = 4'h7;
    dm = 1'b1;
    dq = 8'h00;
  end
  // ==========
  // One memory cycle; clock stands low between cycles
  task automatic issue(input logic c, input logic [2:0] cmd, input logic m,
                       input logic [7:0] d);
    cke = c; // Caller keeps each level three edges, save the one-edge low level of the hold-error test
    // Caller sends only quiet commands, or refresh for self-refresh entry, on cke change edges
    if (cmd == `SCD_CMD_DESELECT) begin
      strb = {1'h1, ~strb[2:0]}; // Don't-care strobes keep moving
    end else if (cmd == `SCD_CMD_NOP) begin
      strb = 4'h7;
    end else if (cmd == `SCD_CMD_READ) begin
      strb = 4'h5;
    end else begin
      strb = {1'h0, 3'h7 - cmd}; // Only table commands
    end
    dm = m;
    dq = m ? ~dq : d; // Masked beat carries junk, never a stale copy
    repeat (4) @(posedge ref_clk);
    #1;
    mem_clk = 1'b1; // Pins settled four ref_clk before the rise
    repeat (4) @(posedge ref_clk);
    #1;
    mem_clk = 1'b0; // 200 ns per call; spacing covers exit latency
  endtask
endmodule // scd_ctrl_model

// ==== scd_cmd_decoder_assertions.sv ====
// Checker of the clock-enable state and command decoder outputs.
// Assumes memory edges at least eight ref_clk apart.
`timescale 1ns/1ps
`include "scd_defs.vh"
module scd_cmd_decoder_chk #(
  parameter DATA_W = 8
) (
  input wire ref_clk,
  input wire nrst,
  input wire [2:0] bank_state,
  input wire illegal_cmd,
  input wire action_valid,
  input wire [2:0] action_code,
  input wire odt_effective,
  input wire beat_lost,
  input wire beat_valid,
  input wire beat_ready,
  input wire [DATA_W-1:0] beat_data
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_ill_keep; illegal_cmd |-> bank_state == $past(bank_state); endproperty
  property p_ill_once; illegal_cmd |=> !illegal_cmd [*7]; endproperty
  property p_ill_noact; illegal_cmd |-> !action_valid; endproperty
  property p_sr_odt;
    bank_state == `SCD_ST_SELF ##1 bank_state == `SCD_ST_SELF |-> !odt_effective;
  endproperty
  property p_entry;
    action_valid && action_code == `SCD_ACT_PD_ENTRY |-> bank_state inside
      {`SCD_ST_PD_PRE, `SCD_ST_PD_ACT, `SCD_ST_SELF} && $past(bank_state) <= `SCD_ST_ACTIVE;
  endproperty
  property p_entry_act;
    action_valid && action_code == `SCD_ACT_PD_ENTRY && $past(bank_state) == `SCD_ST_ACTIVE
      |-> bank_state == `SCD_ST_PD_ACT;
  endproperty
  property p_exit;
    action_valid && action_code == `SCD_ACT_EXIT |-> $past(bank_state) >= `SCD_ST_PD_PRE
      && bank_state <= `SCD_ST_ACTIVE;
  endproperty
  property p_store;
    action_valid && action_code == `SCD_ACT_STORE |-> bank_state == `SCD_ST_WRITE;
  endproperty
  property p_read;
    action_valid && action_code == `SCD_ACT_READ |-> bank_state == `SCD_ST_READ
      && $past(bank_state) == `SCD_ST_ACTIVE;
  endproperty
  property p_buf_hold;
    beat_valid && !beat_ready |=> beat_valid && $stable(beat_data);
  endproperty
  a_ill_keep: assert property (p_ill_keep) else $error("state moved on illegal");
  a_ill_once: assert property (p_ill_once) else $error("illegal pulse too long");
  a_ill_noact: assert property (p_ill_noact) else $error("action on illegal");
  a_sr_odt: assert property (p_sr_odt) else $error("termination in self refresh");
  a_entry: assert property (p_entry) else $error("bad low power entry");
  a_entry_act: assert property (p_entry_act) else $error("wrong power-down kind");
  a_exit: assert property (p_exit) else $error("bad low power exit");
  a_store: assert property (p_store) else $error("store without write state");
  a_read: assert property (p_read) else $error("read from wrong state");
  a_buf_hold: assert property (p_buf_hold) else $error("beat changed while stalled");
  c_ill: cover property (illegal_cmd);
  c_self: cover property (bank_state == `SCD_ST_SELF);
  c_lost: cover property (beat_lost);
endmodule // scd_cmd_decoder_chk

bind scd_cmd_decoder scd_cmd_decoder_chk #(.DATA_W(DATA_W)) u_chk (
  .ref_clk(ref_clk), .nrst(nrst), .bank_state(bank_state), .illegal_cmd(illegal_cmd),
  .action_valid(action_valid), .action_code(action_code), .odt_effective(odt_effective),
  .beat_lost(beat_lost), .beat_valid(beat_valid), .beat_ready(beat_ready),
  .beat_data(beat_data));

// ==== tb_sdram_command_state_decoder.sv ====
// Testbench of the clock-enable state and command decoder.
// Assumes the controller model and the bound checker are compiled first.
`timescale 1ns/1ps
`include "scd_defs.vh"
module tb_sdram_command_state_decoder;
  localparam logic [2:0] nop = `SCD_CMD_NOP;
  localparam logic [2:0] ds = `SCD_CMD_DESELECT;
  localparam logic [2:0] rd = `SCD_CMD_READ;
  localparam logic [2:0] st = `SCD_CMD_STORE;
  localparam logic [2:0] ro = `SCD_CMD_ROW_OPEN;
  localparam logic [2:0] bc = `SCD_CMD_BANK_CLOSE;
  localparam logic [2:0] rf = `SCD_CMD_REFRESH;
  localparam logic [2:0] ml = `SCD_CMD_MODE_LOAD;
  localparam logic [2:0] s_id = `SCD_ST_IDLE;
  localparam logic [2:0] s_ac = `SCD_ST_ACTIVE;
  localparam logic [2:0] s_rd = `SCD_ST_READ;
  localparam logic [2:0] s_wr = `SCD_ST_WRITE;
  localparam logic [2:0] s_pp = `SCD_ST_PD_PRE;
  localparam logic [2:0] s_pa = `SCD_ST_PD_ACT;
  localparam logic [2:0] s_sr = `SCD_ST_SELF;
  // Flags: bit 1 illegal expected, bit 0 action expected
  typedef struct packed {logic ck; logic [2:0] cmd; logic [2:0] state; logic [1:0] f;
    logic [2:0] code;} scd_row_t;
  logic ref_clk, nrst, on_die_termination, beat_ready, mem_clk, cke, dm;
  logic [3:0] strb;
  logic [7:0] dq, beat_data;
  logic [2:0] bank_state, action_code, seen_code;
  logic illegal_cmd, cke_hold_err, action_valid, odt_effective, beat_lost, beat_valid;
  logic seen_ill, seen_act, seen_hold, seen_lost;
  int fails, n_checks;
  scd_row_t rows [$] = '{
    '{1'h1, ds, s_id, 2'h0, 3'h0}, '{1'h1, rd, s_id, 2'h2, 3'h0},
    '{1'h1, st, s_id, 2'h2, 3'h0}, '{1'h1, bc, s_id, 2'h1, 3'h1},
    '{1'h1, rf, s_id, 2'h1, 3'h2}, '{1'h1, ml, s_id, 2'h1, 3'h3},
    '{1'h1, ro, s_ac, 2'h1, 3'h0}, '{1'h1, ro, s_ac, 2'h2, 3'h0},
    '{1'h1, rf, s_ac, 2'h2, 3'h0}, '{1'h1, ml, s_ac, 2'h2, 3'h0},
    '{1'h1, nop, s_ac, 2'h0, 3'h0}, '{1'h1, rd, s_rd, 2'h1, 3'h4},
    '{1'h1, st, s_rd, 2'h2, 3'h0}, '{1'h1, ro, s_rd, 2'h2, 3'h0},
    '{1'h1, rd, s_rd, 2'h2, 3'h0}, '{1'h1, nop, s_rd, 2'h0, 3'h0},
    '{1'h1, nop, s_rd, 2'h0, 3'h0}, '{1'h1, nop, s_rd, 2'h0, 3'h0},
    '{1'h1, nop, s_ac, 2'h0, 3'h0}, '{1'h1, st, s_wr, 2'h1, 3'h5},
    '{1'h1, rd, s_wr, 2'h2, 3'h0}, '{1'h1, bc, s_wr, 2'h2, 3'h0},
    '{1'h1, nop, s_wr, 2'h0, 3'h0}, '{1'h1, nop, s_wr, 2'h0, 3'h0},
    '{1'h1, nop, s_wr, 2'h0, 3'h0}, '{1'h1, nop, s_ac, 2'h0, 3'h0},
    '{1'h0, nop, s_pa, 2'h1, 3'h6}, '{1'h0, nop, s_pa, 2'h0, 3'h0},
    '{1'h0, rd, s_pa, 2'h0, 3'h0}, '{1'h1, nop, s_ac, 2'h1, 3'h7},
    '{1'h1, nop, s_ac, 2'h0, 3'h0}, '{1'h1, bc, s_id, 2'h1, 3'h1},
    '{1'h0, nop, s_pp, 2'h1, 3'h6}, '{1'h0, ds, s_pp, 2'h0, 3'h0},
    '{1'h0, nop, s_pp, 2'h0, 3'h0}, '{1'h1, nop, s_id, 2'h1, 3'h7},
    '{1'h1, nop, s_id, 2'h0, 3'h0}, '{1'h1, nop, s_id, 2'h0, 3'h0},
    '{1'h0, rf, s_sr, 2'h1, 3'h6}, '{1'h0, nop, s_sr, 2'h0, 3'h0},
    '{1'h0, ml, s_sr, 2'h0, 3'h0}, '{1'h1, ds, s_id, 2'h1, 3'h7}};

  scd_ctrl_model u_ctrl (.ref_clk(ref_clk), .mem_clk(mem_clk), .cke(cke), .strb(strb),
    .dm(dm), .dq(dq));
  scd_cmd_decoder #(.DATA_W(8), .BURST_LEN(4), .XSNR_CLKS(8)) u_dut (.ref_clk(ref_clk),
    .nrst(nrst), .mem_clk(mem_clk), .cke(cke), .cs_n(strb[3]), .ras_n(strb[2]),
    .cas_n(strb[1]), .we_n(strb[0]), .on_die_termination(on_die_termination), .data_mask_input(dm), .dq(dq),
    .bank_state(bank_state), .illegal_cmd(illegal_cmd), .cke_hold_err(cke_hold_err),
    .action_valid(action_valid), .action_code(action_code), .odt_effective(odt_effective),
    .beat_lost(beat_lost), .beat_valid(beat_valid), .beat_ready(beat_ready),
    .beat_data(beat_data));

  always #12.5 ref_clk = ~ref_clk;
  // ==========
  // Pulses last one cycle, so they are latched until the next step
  always @(posedge ref_clk) begin
    if (illegal_cmd) seen_ill <= 1'b1;
    if (action_valid) seen_act <= 1'b1;
    if (action_valid) seen_code <= action_code;
    if (cke_hold_err) seen_hold <= 1'b1;
    if (beat_lost) seen_lost <= 1'b1;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input logic c, input logic [2:0] cmd, input logic m,
                      input logic [7:0] d);
    seen_ill = 1'b0;
    seen_act = 1'b0;
    seen_hold = 1'b0;
    seen_lost = 1'b0;
    u_ctrl.issue(c, cmd, m, d);
  endtask
  task automatic pop(input logic [7:0] exp);
    chk(beat_valid, 8'h01);
    chk(beat_data, exp);
    beat_ready = 1'b1;
    @(posedge ref_clk);
    #1;
    beat_ready = 1'b0;
  endtask
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #80000;
    fails++;
    finish_test;
  end
  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    on_die_termination = 1'b0;
    beat_ready = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    chk(bank_state, s_id);
    chk(beat_valid, 8'h00);
    nrst = 1'b1;
    on_die_termination = 1'b1;
    foreach (rows[i]) begin
      step(rows[i].ck, rows[i].cmd, 1'h1, 8'h00);
      chk(bank_state, rows[i].state);
      chk(seen_ill, rows[i].f[1]);
      chk(seen_act, rows[i].f[0]);
      if (rows[i].f[0]) chk(seen_code, rows[i].code);
      chk(odt_effective, bank_state != s_sr);
      chk(seen_hold, 8'h00);
    end
    chk(beat_valid, 8'h00);
    // First window edge refuses a command; the ninth edge takes it
    step(1'h1, ro, 1'h1, 8'h00);
    chk(seen_ill, 8'h01);
    repeat (7) step(1'h1, nop, 1'h1, 8'h00);
    step(1'h1, ro, 1'h1, 8'h00);
    chk(seen_act, 8'h01);
    // Reads stay refused until the long exit delay runs out
    step(1'h1, rd, 1'h1, 8'h00);
    chk(seen_ill, 8'h01);
    // Receiver stalls: two unmasked beats fill the buffer, the third is lost
    step(1'h1, st, 1'h1, 8'h00);
    step(1'h1, nop, 1'h0, 8'h11);
    step(1'h1, nop, 1'h1, 8'h22);
    step(1'h1, nop, 1'h0, 8'h33);
    step(1'h1, nop, 1'h0, 8'h44);
    chk(seen_lost, 8'h01);
    chk(bank_state, s_ac);
    pop(8'h11);
    pop(8'h33);
    chk(beat_valid, 8'h00);
    // Clock enable toggled back after a single registration
    step(1'h1, bc, 1'h1, 8'h00);
    step(1'h0, nop, 1'h1, 8'h00);
    step(1'h1, nop, 1'h1, 8'h00);
    chk(seen_hold, 8'h01);
    nrst = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    chk(bank_state, s_id);
    chk(odt_effective, 8'h00);
    nrst = 1'b1;
    step(1'h1, nop, 1'h1, 8'h00);
    chk(seen_ill, 8'h00);
    chk(seen_act, 8'h00);
    finish_test;
  end
endmodule // tb_sdram_command_state_decoder
